/* File: dv/ctd_calc_dma_tb_top.sv */
// Self-checking bench for the calculation-transfer channel over APB and the pin.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module ctd_calc_dma_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rstn, externalTriggerInput, psel, penable, pwrite, slowMode;
	logic [31:0] paddr, pwdata, prdata, memAddr, memWdata, memRdata, rd, w;
	logic pready, pslverr, memReq, memWe, memHalf, memAck, cpuIrqReq, irq, er;
	int wrCnt, wrBase, c;
	int failures = 0;
	int checks_done = 0;
	int cpuReqCnt = 0;

	ctd_calc_dma ctd_calc_dma_i (.ref_clk(ref_clk), .rstn(rstn),
		.externalTriggerInput(externalTriggerInput), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .memReq(memReq), .memWe(memWe), .memHalf(memHalf),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
		.cpuIrqReq(cpuIrqReq), .irq(irq));
	ctd_mem_model ctd_mem_model_i (.ref_clk(ref_clk), .rstn(rstn), .memReq(memReq),
		.memWe(memWe), .memHalf(memHalf), .memAddr(memAddr), .memWdata(memWdata),
		.slowMode(slowMode), .memRdata(memRdata), .memAck(memAck), .wrCnt(wrCnt));

	// Free-running 50 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Counts ordinary interrupt requests handed to the processor.
	always @(posedge ref_clk) begin
		if (cpuIrqReq === 1'b1) cpuReqCnt <= cpuReqCnt + 1;
	end

	task automatic finish_test();
		$display("Checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {24'h000000, ofs};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) failures++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic put32(input logic [31:0] a, input logic [31:0] v);
		for (int k = 0; k < 4; k++) ctd_mem_model_i.mem[a + k] = v[8 * k +: 8];
	endtask

	function automatic logic [31:0] wordAt(input logic [31:0] a);
		return {ctd_mem_model_i.mem[a + 3], ctd_mem_model_i.mem[a + 2],
			ctd_mem_model_i.mem[a + 1], ctd_mem_model_i.mem[a]};
	endfunction

	task automatic setDesc(input logic [31:0] b, input logic [15:0] ctl, input logic [15:0] n,
		input logic [31:0] s, input logic [31:0] o, input logic [31:0] d);
		put32(b, {n, ctl});
		put32(b + 4, s);
		put32(b + 8, o);
		put32(b + 12, d);
	endtask

	// Pulses the pin, then waits for nWr memory writes; a refused trigger gets 40 cycles.
	task automatic trig(input int nWr);
		int n;
		wrBase = wrCnt;
		@(posedge ref_clk);
		externalTriggerInput <= 1'b1;
		repeat (3) @(posedge ref_clk);
		externalTriggerInput <= 1'b0;
		n = 0;
		while (n < 600 && (nWr == 0 ? n < 40 : wrCnt != wrBase + nWr)) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (4) @(posedge ref_clk);
	endtask

	// Watchdog: the whole sequence needs well under 5000 cycles.
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		finish_test();
	end

	// Main sequence.
	initial begin
		rstn = 1'b0;
		externalTriggerInput = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		slowMode = 1'b0;
		for (int i = 0; i < 5; i++) begin
			ctd_mem_model_i.mem[32'h400 + i] = 8'(16 * (i + 1));
			ctd_mem_model_i.mem[32'h405 + i] = 8'(i + 1);
		end
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, ctd_pkg::CTRL_OFS, 32'h0);
		`CHK(rd, ctd_pkg::CTRL_RST);
		apb(1'b0, ctd_pkg::VBASE_OFS, 32'h0);
		`CHK(rd, ctd_pkg::VBASE_RST);
		apb(1'b0, ctd_pkg::MASK_OFS, 32'h0);
		`CHK(rd, {30'h0, ctd_pkg::MASK_RST});
		apb(1'b0, 8'h40, 32'h0);
		`CHK(er, 1'b1);
		// Byte run of five with fixed destination and completion interrupt enabled.
		setDesc(32'h200, 16'h0074, 16'h0005, 32'h400, 32'h405, 32'h1000);
		put32(ctd_pkg::VEC_NUM * ctd_pkg::VEC_BYTES, 32'h200);
		apb(1'b1, ctd_pkg::VBASE_OFS, 32'h0);
		apb(1'b1, ctd_pkg::MASK_OFS, 32'h3);
		apb(1'b1, ctd_pkg::CTRL_OFS, 32'h71);
		for (int i = 0; i < 5; i++) begin
			trig(5);
			`CHK(wrCnt, wrBase + 5);
			`CHK(ctd_mem_model_i.mem[32'h1000], 8'(17 * (i + 1)));
			apb(1'b0, ctd_pkg::LSUM_OFS, 32'h0);
			`CHK(rd, 32'(17 * (i + 1)));
			w = wordAt(32'h200);
			`CHK(w[31:16], 16'(4 - i));
			`CHK(wordAt(32'h204), 32'(32'h401 + i));
			`CHK(wordAt(32'h208), 32'(32'h406 + i));
			`CHK(wordAt(32'h20C), 32'h0000_1000);
		end
		apb(1'b0, ctd_pkg::STAT_OFS, 32'h0);
		`CHK(rd[ctd_pkg::ST_DONE_BIT], 1'b1);
		`CHK(irq, 1'b1);
		// Mask the refusal event, clear, then trigger with the counter at zero.
		apb(1'b1, ctd_pkg::MASK_OFS, 32'h1);
		apb(1'b1, ctd_pkg::STAT_OFS, 32'h3);
		apb(1'b0, ctd_pkg::STAT_OFS, 32'h0);
		`CHK(rd, 32'h0);
		trig(0);
		`CHK(wrCnt, wrBase);
		apb(1'b0, ctd_pkg::STAT_OFS, 32'h0);
		`CHK(rd[ctd_pkg::ST_IGN_BIT], 1'b1);
		`CHK(irq, 1'b0);
		// A request at another level goes to the processor and moves nothing.
		apb(1'b1, ctd_pkg::CTRL_OFS, 32'h31);
		c = cpuReqCnt;
		trig(0);
		`CHK(cpuReqCnt, c + 1);
		`CHK(wrCnt, wrBase);
		// Halfword run of two from a new vector entry, slow memory, no completion interrupt.
		slowMode <= 1'b1;
		apb(1'b1, ctd_pkg::STAT_OFS, 32'h3);
		put32(ctd_pkg::VEC_NUM * ctd_pkg::VEC_BYTES, 32'h300);
		setDesc(32'h300, 16'h003D, 16'h0002, 32'h500, 32'h600, 32'h700);
		put32(32'h500, 32'h0F0F_1234);
		put32(32'h600, 32'h2222_1111);
		apb(1'b1, ctd_pkg::CTRL_OFS, 32'h71);
		trig(5);
		trig(5);
		`CHK(wrCnt, wrBase + 5);
		`CHK(wordAt(32'h700), 32'h3131_2345);
		`CHK(wordAt(32'h304), 32'h0000_0504);
		`CHK(wordAt(32'h308), 32'h0000_0604);
		apb(1'b0, ctd_pkg::STAT_OFS, 32'h0);
		`CHK(rd[ctd_pkg::ST_DONE_BIT], 1'b0);
		// Moved vector table; a block-mode plain copy chains into a calculated run.
		apb(1'b1, ctd_pkg::VBASE_OFS, 32'h100);
		apb(1'b0, ctd_pkg::VBASE_OFS, 32'h0);
		`CHK(rd, 32'h0000_0100);
		put32(32'h100 + ctd_pkg::VEC_NUM * ctd_pkg::VEC_BYTES, 32'h240);
		setDesc(32'h240, 16'h008C, 16'h0002, 32'h410, 32'h0, 32'h1100);
		put32(32'h250, 32'h280);
		setDesc(32'h280, 16'h0054, 16'h0001, 32'h400, 32'h405, 32'h1200);
		put32(32'h410, 32'h0000_A55A);
		trig(15);
		`CHK(wrCnt, wrBase + 15);
		`CHK(ctd_mem_model_i.mem[32'h1100], 8'h5A);
		`CHK(ctd_mem_model_i.mem[32'h1101], 8'hA5);
		`CHK(wordAt(32'h244), 32'h0000_0412);
		`CHK(wordAt(32'h248), 32'h0000_0000);
		`CHK(wordAt(32'h24C), 32'h0000_1102);
		`CHK(ctd_mem_model_i.mem[32'h1200], 8'h11);
		`CHK(wordAt(32'h28C), 32'h0000_1200);
		apb(1'b0, ctd_pkg::CHST_OFS, 32'h0);
		`CHK(rd, {16'h0000, 8'h00, 8'(ctd_pkg::ST_IDLE)});
		apb(1'b0, ctd_pkg::STAT_OFS, 32'h0);
		`CHK(rd[ctd_pkg::ST_DONE_BIT], 1'b1);
		`CHK(irq, 1'b1);
		finish_test();
	end
endmodule

/* File: dv/ctd_mem_model.sv */
// Behavioural on-chip memory that answers the channel's memory port.
module ctd_mem_model #(
	parameter logic [31:0] WORD_LIMIT = 32'h0000_0400
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic memHalf,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	input wire logic slowMode,
	output logic [31:0] memRdata,
	output logic memAck,
	output int wrCnt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:8191];
	int waitCnt;
	logic [12:0] a;

	assign a = memAddr[12:0];

	// One access per request; slow mode stalls three extra cycles. Idle read data toggles
	// every cycle so that stale data can never pass for a fresh answer. Below WORD_LIMIT
	// non-halfword accesses are descriptor or vector words and move four bytes.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			memAck <= 1'b0;
			waitCnt <= 0;
			wrCnt <= 0;
			memRdata <= 32'h0000_0000;
		end else if (memAck) begin
			memAck <= 1'b0;
			memRdata <= ~memRdata;
		end else if (memReq === 1'b1 && slowMode && waitCnt < 3) begin
			waitCnt <= waitCnt + 1;
			memRdata <= ~memRdata;
		end else if (memReq === 1'b1) begin
			waitCnt <= 0;
			memAck <= 1'b1;
			if (memWe) begin
				wrCnt <= wrCnt + 1;
				mem[a] <= memWdata[7:0];
				if (memHalf || memAddr < WORD_LIMIT) begin
					mem[a + 13'h1] <= memWdata[15:8];
				end
				if (!memHalf && memAddr < WORD_LIMIT) begin
					mem[a + 13'h2] <= memWdata[23:16];
					mem[a + 13'h3] <= memWdata[31:24];
				end
			end else begin
				memRdata <= {mem[a + 13'h3], mem[a + 13'h2], mem[a + 13'h1], mem[a]};
			end
		end else begin
			memRdata <= ~memRdata;
		end
	end
endmodule

/* File: hdl/ctd_calc_dma.sv */
module ctd_calc_dma (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic externalTriggerInput,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic memReq,
	output logic memWe,
	output logic memHalf,
	output logic [31:0] memAddr,
	output logic [31:0] memWdata,
	input wire logic [31:0] memRdata,
	input wire logic memAck,
	output logic cpuIrqReq,
	output logic irq
);
	logic trigRise;
	logic [31:0] ctrl_ff, nxt_ctrl, vbase_ff, nxt_vbase;
	logic [1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
	logic nxt_pready, nxt_pslverr, nxt_irq, nxt_cpuIrq;
	logic [31:0] nxt_prdata;
	ctd_pkg::ctd_state_e state_ff, nxt_state;
	logic [2:0] idx_ff, nxt_idx;
	logic [15:0] ctl_ff, nxt_ctl, cnt_ff, nxt_cnt, data_ff, nxt_data, lsum_ff, nxt_lsum;
	logic [31:0] desc_ff, nxt_desc, src_ff, nxt_src, opr_ff, nxt_opr, dst_ff, nxt_dst;
	logic pend_ff, nxt_pend, doneEvt, ignEvt;
	logic nxt_memReq, nxt_memWe, nxt_memHalf;
	logic [31:0] nxt_memAddr, nxt_memWdata;
	logic apbWr, trigHit, size16;
	logic [15:0] dmask;
	logic [31:0] step;

	// The pin is the only trigger source; it is synchronised before use.
	ctd_trig_sync u_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pinIn(externalTriggerInput),
		.riseOut(trigRise)
	);

	// Descriptor word image used when writing the channel state back.
	function automatic logic [31:0] descWord(input logic [2:0] i, input logic [15:0] c,
		input logic [15:0] k, input logic [31:0] s, input logic [31:0] o, input logic [31:0] d);
		logic [31:0] w;
		w = {c, k};
		if (i == 3'h1) w = s;
		if (i == 3'h2) w = o;
		if (i == 3'h3) w = d;
		return w;
	endfunction

	assign apbWr = psel & penable & pready & pwrite;
	assign trigHit = trigRise & ctrl_ff[ctd_pkg::CTRL_EN_BIT]
		& (ctrl_ff[ctd_pkg::CTRL_LVL_LSB +: 3] == ctd_pkg::TRIG_LEVEL);
	assign size16 = ctl_ff[ctd_pkg::D_SIZE16];
	assign dmask = size16 ? 16'hFFFF : 16'h00FF;
	assign step = size16 ? 32'h0000_0002 : 32'h0000_0001;

	// APB slave: answer is prepared in the setup cycle, so pready rises in the first
	// access cycle and every access takes exactly two cycles.
	always_comb begin
		nxt_pready = psel & ~penable;
		nxt_pslverr = 1'b0;
		nxt_prdata = 32'h0000_0000;
		nxt_ctrl = ctrl_ff;
		nxt_vbase = vbase_ff;
		nxt_mask = mask_ff;
		if (psel && !penable) begin
			unique case (paddr[7:0])
				ctd_pkg::CTRL_OFS: nxt_prdata = ctrl_ff;
				ctd_pkg::VBASE_OFS: nxt_prdata = vbase_ff;
				ctd_pkg::STAT_OFS: nxt_prdata = {30'h0, stat_ff};
				ctd_pkg::MASK_OFS: nxt_prdata = {30'h0, mask_ff};
				ctd_pkg::LSUM_OFS: nxt_prdata = {16'h0, lsum_ff};
				ctd_pkg::CHST_OFS: nxt_prdata = {cnt_ff, 8'h0, state_ff};
				default: nxt_pslverr = 1'b1;
			endcase
			if (paddr[31:8] != 24'h0) begin
				nxt_pslverr = 1'b1;
				nxt_prdata = 32'h0000_0000;
			end
		end
		if (apbWr && paddr[31:8] == 24'h0) begin
			if (paddr[7:0] == ctd_pkg::CTRL_OFS) nxt_ctrl = pwdata;
			if (paddr[7:0] == ctd_pkg::VBASE_OFS) nxt_vbase = pwdata;
			if (paddr[7:0] == ctd_pkg::MASK_OFS) nxt_mask = pwdata[1:0];
		end
	end

	// Sticky status: writing one clears a bit, but an event in the same cycle wins.
	always_comb begin
		nxt_stat = stat_ff;
		if (apbWr && paddr == {24'h0, ctd_pkg::STAT_OFS}) nxt_stat = stat_ff & ~pwdata[1:0];
		if (doneEvt) nxt_stat[ctd_pkg::ST_DONE_BIT] = 1'b1;
		if (ignEvt) nxt_stat[ctd_pkg::ST_IGN_BIT] = 1'b1;
		nxt_irq = |(nxt_stat & mask_ff);
	end

	// Trigger intake: a level-7 request becomes a pending DMA trigger; any other
	// level is passed on as an ordinary interrupt request for one cycle.
	always_comb begin
		nxt_pend = pend_ff;
		if (state_ff == ctd_pkg::ST_IDLE) nxt_pend = 1'b0;
		if (trigHit) nxt_pend = 1'b1;
		nxt_cpuIrq = trigRise & ctrl_ff[ctd_pkg::CTRL_EN_BIT] & ~trigHit;
	end

	// Channel sequencer. Memory requests are held until memAck, and only one is
	// outstanding, so the memory side sets the pace of every step.
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_desc = desc_ff;
		nxt_ctl = ctl_ff;
		nxt_cnt = cnt_ff;
		nxt_src = src_ff;
		nxt_opr = opr_ff;
		nxt_dst = dst_ff;
		nxt_data = data_ff;
		nxt_lsum = lsum_ff;
		nxt_memReq = memReq & ~memAck;
		nxt_memWe = memWe;
		nxt_memHalf = memHalf;
		nxt_memAddr = memAddr;
		nxt_memWdata = memWdata;
		doneEvt = 1'b0;
		ignEvt = 1'b0;
		unique case (state_ff)
			ctd_pkg::ST_IDLE: begin
				if (pend_ff) begin
					// Read the trigger vector entry to find the descriptor.
					nxt_memReq = 1'b1;
					nxt_memWe = 1'b0;
					nxt_memHalf = 1'b0;
					nxt_memAddr = vbase_ff + ctd_pkg::VEC_NUM * ctd_pkg::VEC_BYTES;
					nxt_state = ctd_pkg::ST_VEC;
				end
			end
			ctd_pkg::ST_VEC, ctd_pkg::ST_CHAIN: begin
				if (memAck) begin
					nxt_desc = memRdata;
					nxt_idx = ctd_pkg::W_CTL;
					nxt_memReq = 1'b1;
					nxt_memAddr = memRdata;
					nxt_state = ctd_pkg::ST_DESC;
				end
			end
			ctd_pkg::ST_DESC: begin
				if (memAck) begin
					unique case (idx_ff)
						3'h0: begin
							nxt_ctl = memRdata[15:0];
							nxt_cnt = memRdata[ctd_pkg::D_CNT_LSB +: 16];
						end
						3'h1: nxt_src = memRdata;
						3'h2: nxt_opr = memRdata;
						default: nxt_dst = memRdata;
					endcase
					if (idx_ff != ctd_pkg::W_DST) begin
						nxt_idx = idx_ff + 3'h1;
						nxt_memReq = 1'b1;
						nxt_memAddr = memAddr + 32'h0000_0004;
					end else if (cnt_ff == 16'h0000) begin
						ignEvt = 1'b1;
						nxt_state = ctd_pkg::ST_IDLE;
					end else begin
						nxt_memReq = 1'b1;
						nxt_memHalf = size16;
						nxt_memAddr = src_ff;
						nxt_state = ctd_pkg::ST_RSRC;
					end
				end
			end
			ctd_pkg::ST_RSRC: begin
				if (memAck) begin
					nxt_data = memRdata[15:0] & dmask;
					nxt_memReq = 1'b1;
					if (ctl_ff[ctd_pkg::D_CALC]) begin
						nxt_memAddr = opr_ff;
						nxt_state = ctd_pkg::ST_ROPR;
					end else begin
						// Plain transfer: the source datum goes out unchanged.
						nxt_memWe = 1'b1;
						nxt_memAddr = dst_ff;
						nxt_memWdata = {16'h0, memRdata[15:0] & dmask};
						nxt_state = ctd_pkg::ST_WDST;
					end
				end
			end
			ctd_pkg::ST_ROPR: begin
				if (memAck) begin
					// The sum wraps within the transfer size.
					nxt_lsum = (data_ff + memRdata[15:0]) & dmask;
					nxt_memReq = 1'b1;
					nxt_memWe = 1'b1;
					nxt_memAddr = dst_ff;
					nxt_memWdata = {16'h0, (data_ff + memRdata[15:0]) & dmask};
					nxt_state = ctd_pkg::ST_WDST;
				end
			end
			ctd_pkg::ST_WDST: begin
				if (memAck) begin
					nxt_cnt = cnt_ff - 16'h0001;
					if (ctl_ff[ctd_pkg::D_SRCINC]) nxt_src = src_ff + step;
					if (ctl_ff[ctd_pkg::D_CALC]) nxt_opr = opr_ff + step;
					if (ctl_ff[ctd_pkg::D_DSTINC]) nxt_dst = dst_ff + step;
					nxt_idx = ctd_pkg::W_CTL;
					nxt_memReq = 1'b1;
					nxt_memHalf = 1'b0;
					nxt_memAddr = desc_ff;
					nxt_memWdata = descWord(ctd_pkg::W_CTL, cnt_ff - 16'h0001, ctl_ff,
						src_ff, opr_ff, dst_ff);
					nxt_state = ctd_pkg::ST_WBACK;
				end
			end
			ctd_pkg::ST_WBACK: begin
				// The descriptor is updated in memory so the next trigger resumes.
				if (memAck) begin
					if (idx_ff != ctd_pkg::W_DST) begin
						nxt_idx = idx_ff + 3'h1;
						nxt_memReq = 1'b1;
						nxt_memAddr = memAddr + 32'h0000_0004;
						nxt_memWdata = descWord(idx_ff + 3'h1, cnt_ff, ctl_ff,
							src_ff, opr_ff, dst_ff);
					end else if (cnt_ff == 16'h0000) begin
						doneEvt = ctl_ff[ctd_pkg::D_CMPIRQ];
						nxt_memWe = 1'b0;
						nxt_state = ctd_pkg::ST_IDLE;
						if (ctl_ff[ctd_pkg::D_CHAIN]) begin
							// Chaining: word 4 points at the next descriptor.
							nxt_idx = ctd_pkg::W_LINK;
							nxt_memReq = 1'b1;
							nxt_memAddr = desc_ff + 32'h0000_0010;
							nxt_state = ctd_pkg::ST_CHAIN;
						end
					end else if (!ctl_ff[ctd_pkg::D_SINGLE]) begin
						// Block mode runs the whole count on one trigger.
						nxt_memReq = 1'b1;
						nxt_memWe = 1'b0;
						nxt_memHalf = size16;
						nxt_memAddr = src_ff;
						nxt_state = ctd_pkg::ST_RSRC;
					end else begin
						nxt_memWe = 1'b0;
						nxt_state = ctd_pkg::ST_IDLE;
					end
				end
			end
			default: nxt_state = ctd_pkg::ST_IDLE;
		endcase
	end

	// All state and every output register.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_ff <= ctd_pkg::CTRL_RST;
			vbase_ff <= ctd_pkg::VBASE_RST;
			mask_ff <= ctd_pkg::MASK_RST;
			stat_ff <= 2'h0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
			cpuIrqReq <= 1'b0;
			pend_ff <= 1'b0;
			state_ff <= ctd_pkg::ST_IDLE;
			idx_ff <= 3'h0;
			desc_ff <= 32'h0000_0000;
			ctl_ff <= 16'h0000;
			cnt_ff <= 16'h0000;
			src_ff <= 32'h0000_0000;
			opr_ff <= 32'h0000_0000;
			dst_ff <= 32'h0000_0000;
			data_ff <= 16'h0000;
			lsum_ff <= 16'h0000;
			memReq <= 1'b0;
			memWe <= 1'b0;
			memHalf <= 1'b0;
			memAddr <= 32'h0000_0000;
			memWdata <= 32'h0000_0000;
		end else begin
			ctrl_ff <= nxt_ctrl;
			vbase_ff <= nxt_vbase;
			mask_ff <= nxt_mask;
			stat_ff <= nxt_stat;
			prdata <= nxt_prdata;
			pready <= nxt_pready;
			pslverr <= nxt_pslverr;
			irq <= nxt_irq;
			cpuIrqReq <= nxt_cpuIrq;
			pend_ff <= nxt_pend;
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			desc_ff <= nxt_desc;
			ctl_ff <= nxt_ctl;
			cnt_ff <= nxt_cnt;
			src_ff <= nxt_src;
			opr_ff <= nxt_opr;
			dst_ff <= nxt_dst;
			data_ff <= nxt_data;
			lsum_ff <= nxt_lsum;
			memReq <= nxt_memReq;
			memWe <= nxt_memWe;
			memHalf <= nxt_memHalf;
			memAddr <= nxt_memAddr;
			memWdata <= nxt_memWdata;
		end
	end

	// Checks on the channel behaviour.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	trig_pending_a: assert property (trigHit |=> pend_ff || state_ff == ctd_pkg::ST_VEC)
		else $error("Level-7 trigger was not taken.");
	other_level_a: assert property (trigRise && ctrl_ff[0] && !trigHit |=> cpuIrqReq)
		else $error("Other-level request not passed to the processor.");
	// The sum is checked both against the two data the memory returned and against the sum register.
	sum_write_a: assert property (state_ff == ctd_pkg::ST_ROPR && memAck
		|=> memReq && memWe && memAddr == dst_ff && memWdata[15:0] == lsum_ff
		&& memWdata == (($past(data_ff) + $past(memRdata)) & {16'h0, $past(dmask)}))
		else $error("Sum not written to the destination.");
	count_dec_a: assert property (state_ff == ctd_pkg::ST_WDST && memAck
		|=> cnt_ff == $past(cnt_ff) - 16'h0001)
		else $error("Counter not decremented.");
	half_step_a: assert property (state_ff == ctd_pkg::ST_WDST && memAck && size16
		&& ctl_ff[ctd_pkg::D_SRCINC] |=> src_ff == $past(src_ff) + 32'h0000_0002)
		else $error("Halfword source step is not two.");
	zero_ignore_a: assert property (state_ff == ctd_pkg::ST_DESC && idx_ff == 3'h3
		&& memAck && cnt_ff == 16'h0000 |=> state_ff == ctd_pkg::ST_IDLE && !memReq)
		else $error("Transfer started with counter at zero.");
	no_calc_a: assert property (state_ff == ctd_pkg::ST_RSRC && memAck
		&& !ctl_ff[ctd_pkg::D_CALC] |=> state_ff == ctd_pkg::ST_WDST)
		else $error("Operand read without calculation enable.");
	dst_fixed_a: assert property (state_ff == ctd_pkg::ST_WDST && memAck
		&& !ctl_ff[ctd_pkg::D_DSTINC] |=> $stable(dst_ff))
		else $error("Fixed destination pointer moved.");
	// The base is taken as it stood when the fetch was decided.
	vec_fetch_a: assert property (state_ff == ctd_pkg::ST_IDLE && pend_ff
		|=> memReq && !memWe && memAddr == $past(vbase_ff) + 32'h0000_007C)
		else $error("Vector entry not fetched.");
	// Enabled: the flag must be set. Disabled: no new flag may appear.
	done_irq_a: assert property (state_ff == ctd_pkg::ST_WBACK && memAck
		&& idx_ff == 3'h3 && cnt_ff == 16'h0000
		|=> (ctl_ff[ctd_pkg::D_CMPIRQ] ? stat_ff[0] : (!stat_ff[0] || $past(stat_ff[0]))))
		else $error("Completion flag wrong.");

	calc_cov_c: cover property (state_ff == ctd_pkg::ST_ROPR && memAck);
	ignore_cov_c: cover property (ignEvt);
	chain_cov_c: cover property (state_ff == ctd_pkg::ST_CHAIN && memAck);
	irq_cov_c: cover property (irq);
endmodule

/* File: hdl/ctd_pkg.sv */
// Shared constants for the calculation-transfer DMA channel.
package ctd_pkg;

	// Register offsets on the APB slave, byte addresses.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] VBASE_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] MASK_OFS = 8'h0C;
	localparam logic [7:0] LSUM_OFS = 8'h10;
	localparam logic [7:0] CHST_OFS = 8'h14;

	// Control register fields and reset values.
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_LVL_LSB = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] VBASE_RST = 32'h0000_0000;
	localparam logic [1:0] MASK_RST = 2'h0;

	// Sticky status bits, also the mask layout.
	localparam int ST_DONE_BIT = 0;
	localparam int ST_IGN_BIT = 1;

	// Interrupt level that turns a request into a DMA trigger.
	localparam logic [2:0] TRIG_LEVEL = 3'h7;
	// Vector number of the trigger source; its entry holds the descriptor address.
	localparam logic [31:0] VEC_NUM = 32'h0000_001F;
	localparam logic [31:0] VEC_BYTES = 32'h0000_0004;

	// Descriptor word 0 fields; the counter sits in the upper half.
	localparam int D_SIZE16 = 0;
	localparam int D_MEMTYPE = 1;
	localparam int D_SRCINC = 2;
	localparam int D_DSTINC = 3;
	localparam int D_CALC = 4;
	localparam int D_SINGLE = 5;
	localparam int D_CMPIRQ = 6;
	localparam int D_CHAIN = 7;
	localparam int D_CNT_LSB = 16;
	// Word indices: control, source, operand, destination, chain link.
	localparam logic [2:0] W_CTL = 3'h0;
	localparam logic [2:0] W_DST = 3'h3;
	localparam logic [2:0] W_LINK = 3'h4;

	// Channel sequencer states, one-hot.
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_VEC = 8'h02,
		ST_DESC = 8'h04,
		ST_RSRC = 8'h08,
		ST_ROPR = 8'h10,
		ST_WDST = 8'h20,
		ST_WBACK = 8'h40,
		ST_CHAIN = 8'h80
	} ctd_state_e;

endpackage

/* File: hdl/ctd_trig_sync.sv */
// Two-flop synchroniser and rising-edge detector for the trigger pin.
module ctd_trig_sync (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic pinIn,
	output logic riseOut
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;
	logic nxt_rise;

	// The edge is taken from the second stage only; the first may be metastable.
	always_comb begin
		nxt_rise = sync_ff & ~prev_ff;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
			riseOut <= 1'b0;
		end else begin
			meta_ff <= pinIn;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
			riseOut <= nxt_rise;
		end
	end
endmodule
